// [sfce_consts.vh]
`ifndef SFCE_CONSTS_VH
`define SFCE_CONSTS_VH

// instruction opcodes
`define SFCE_OP_READ        8'h03
`define SFCE_OP_FAST_READ   8'h0b
`define SFCE_OP_DUAL_READ   8'h3b
`define SFCE_OP_PAGE_PROG   8'h02
`define SFCE_OP_SECT_ERASE  8'h20
`define SFCE_OP_BLOCK_ERASE 8'hd8
`define SFCE_OP_CHIP_ERASE  8'hc7
`define SFCE_OP_POWER_DOWN  8'hb9
`define SFCE_OP_RELEASE_PD  8'hab
`define SFCE_OP_WRITE_EN    8'h06
`define SFCE_OP_WRITE_DIS   8'h04
`define SFCE_OP_READ_STATUS 8'h05

// erase kinds on the array port
`define SFCE_ERASE_SECTOR   2'h0
`define SFCE_ERASE_BLOCK    2'h1
`define SFCE_ERASE_CHIP     2'h2

// array geometry: byte address bits of the array, address bits on the link
`define SFCE_ARRAY_ABITS    20
`define SFCE_LINK_ABITS     24

// clock period and self-timed cycle times
`define SFCE_CLK_PERIOD_NS  4
`define SFCE_PROG_TIME_NS   1000000
`define SFCE_SECT_TIME_NS   10000000
`define SFCE_BLOCK_TIME_NS  100000000
`define SFCE_CHIP_TIME_NS   1000000000
`define SFCE_PD_TIME_NS     3000
`define SFCE_PD_CYCLES      ((`SFCE_PD_TIME_NS + `SFCE_CLK_PERIOD_NS - 1) / `SFCE_CLK_PERIOD_NS)

// fifo shape
`define SFCE_FIFO_WIDTH     8
`define SFCE_FIFO_DEPTH     16
`define SFCE_FIFO_AW        4

`endif

// [sfce_engine.v]
// How it works
// - normal read: 03h then 24-bit address
// - sample on rising edge, drive on falling, MSB first
// - address increments per byte until chip select rises
// - reads while busy are ignored
// - fast read 0Bh adds eight dummy clocks
// - dual read 3Bh outputs two bits per clock
// - page program 02h: address plus 1..256 bytes
// - page column wraps; unwritten bytes stay unchanged
// - program and erase need write enable latch set
// - execute only on byte-aligned chip select rise
// - busy during cycle, then clear busy and latch
// - protected region blocks program, sector, block erase
// - any protection blocks chip erase
// - sector erase 20h clears 4K sector
// - block erase D8h clears 64K block
// - chip erase C7h clears whole array
// - B9h enters power-down after entry delay
// - power-down ignores all but release
// - reset starts in normal operation
// - 06h alone sets write enable latch
// - status read accepted even while busy, but ignored in power-down
`timescale 1ns/1ps
`include "sfce_consts.vh"
`default_nettype none

module sfce_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  input  wire             flush,
  // fill side
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  // drain side
  output wire [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage words
  reg [AW-1:0]    wrPtr;           // next slot to fill
  reg [AW-1:0]    rdPtr;           // next slot to drain
  reg [AW:0]      count;           // words held
  wire            doPush;
  wire            doPop;

  assign inReady  = (count != DEPTH[AW:0]);
  assign outValid = (count != {(AW+1){1'b0}});
  assign outData  = mem[rdPtr];
  assign doPush   = inValid & inReady;
  assign doPop    = outReady & outValid;

  // storage has no reset, only pointers matter
  always @(posedge clk)
  begin
    if (doPush)
      mem[wrPtr] <= inData;
  end

  // pointers and fill count; flush drops everything at once
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else if (flush)
    begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else
    begin
      if (doPush)
        wrPtr <= wrPtr + {{(AW-1){1'b0}}, 1'b1};
      if (doPop)
        rdPtr <= rdPtr + {{(AW-1){1'b0}}, 1'b1};
      if (doPush & ~doPop)
        count <= count + {{AW{1'b0}}, 1'b1};
      else if (doPop & ~doPush)
        count <= count - {{AW{1'b0}}, 1'b1};
    end
  end
endmodule

module sfce_engine #(
  parameter [31:0] PROG_CYCLES  = `SFCE_PROG_TIME_NS / `SFCE_CLK_PERIOD_NS,
  parameter [31:0] SECT_CYCLES  = `SFCE_SECT_TIME_NS / `SFCE_CLK_PERIOD_NS,
  parameter [31:0] BLOCK_CYCLES = `SFCE_BLOCK_TIME_NS / `SFCE_CLK_PERIOD_NS,
  parameter [31:0] CHIP_CYCLES  = `SFCE_CHIP_TIME_NS / `SFCE_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // serial link pins
  input  wire        chipSelectN,
  input  wire        serialClock,
  input  wire        serialIoLineIn,
  output reg         serialIoLineOut,
  output reg         serialIoLineOe,
  output reg         dataOut,
  // protection settings and status
  input  wire [2:0]  blockProtectField,
  input  wire        topBottomSelect,
  output reg         busy,
  output reg         writeEnableLatch,
  output reg         powerDown,
  // array read port, data one cycle after request
  output reg         memRdEn,
  output reg  [23:0] memRdAddr,
  input  wire [7:0]  memRdData,
  // array program port, array ands the data into the cell
  output reg         memWrEn,
  output reg  [23:0] memWrAddr,
  output reg  [7:0]  memWrData,
  // array erase port
  output reg         memEraseEn,
  output reg  [23:0] memEraseAddr,
  output reg  [1:0]  memEraseKind
);
  // serial states, one-hot
  localparam [8:0] S_OPC  = 9'h001; // shifting opcode
  localparam [8:0] S_ADDR = 9'h002; // shifting address
  localparam [8:0] S_DUM  = 9'h004; // dummy clocks
  localparam [8:0] S_RD   = 9'h008; // streaming array data
  localparam [8:0] S_PROG = 9'h010; // taking program bytes
  localparam [8:0] S_STAT = 9'h020; // streaming status
  localparam [8:0] S_WAIT = 9'h040; // single byte done, expect deselect
  localparam [8:0] S_ADON = 9'h080; // erase address done, expect deselect
  localparam [8:0] S_IGN  = 9'h100; // discard until deselect
  // execution states, one-hot
  localparam [2:0] X_IDLE = 3'h1;
  localparam [2:0] X_WR   = 3'h2;   // pushing page buffer into the array
  localparam [2:0] X_TIME = 3'h4;   // self-timed wait
  // power-down entry count, rounded up to whole clocks, fits the 16-bit counter
  localparam [31:0] PD_LOAD = `SFCE_PD_CYCLES;

  // true when the address falls in the protected region
  function isProtected;
    input [23:0] a;
    input [2:0]  bp;
    input        tb;
    reg   [19:0] rel;
    begin
      rel = tb ? ~a[19:0] : a[19:0];
      // bottom region is the low end, top the high end; bp 7 covers all
      rel = ~rel;
      isProtected = (bp != 3'h0) && ((rel >> (`SFCE_ARRAY_ABITS - 7 + bp)) == 20'h00000);
    end
  endfunction

  // pin synchronisers and edge history
  reg        csS1, csS2, csS3;       // chip select
  reg        sckS1, sckS2, sckS3;    // serial clock
  reg        dinS1, dinS2;           // serial input
  wire       csAct   = ~csS2;
  wire       csRise  = csS2 & ~csS3;
  wire       riseEv  = csAct & sckS2 & ~sckS3;
  wire       fallEv  = csAct & ~sckS2 & sckS3;

  // serial side
  reg [8:0]  sState;                 // serial state
  reg [2:0]  bitCnt;                 // bit within byte
  reg [1:0]  byteIdx;                // address byte index
  reg [7:0]  shIn;                   // input shifter
  reg [7:0]  opc;                    // latched opcode
  reg [23:0] addr;                   // latched address
  reg [7:0]  col;                    // page column for program
  reg        progGot;                // at least one full program byte
  reg [7:0]  pageBuf [0:255];        // page buffer
  reg [255:0] pageMask;              // bytes written in this page
  wire [7:0] inByte = {shIn[6:0], dinS2};

  // output side
  reg [2:0]  outBit;                 // falls within current byte
  reg [7:0]  outSh;                  // output shifter
  wire       dual = (opc == `SFCE_OP_DUAL_READ);
  wire [7:0] statusByte = {2'h0, topBottomSelect, blockProtectField, writeEnableLatch, busy};

  // prefetch and fifo
  reg [23:0] rdAddr;                 // next array address to fetch
  reg        rdPush;                 // array data arrives this cycle
  wire       fifoInReady;
  wire [7:0] fifoData;
  wire       fifoValid;
  wire       inRead  = csAct & ((sState == S_RD) | (sState == S_DUM));
  wire       firstFall = fallEv & (outBit == 3'h0);
  wire       fifoPop = firstFall & (sState == S_RD);

  // execution side
  reg [2:0]  xState;
  reg [7:0]  wrIdx;                  // page buffer scan index
  reg [31:0] timer;                  // self-timed count
  reg [15:0] pdCnt;                  // power-down entry count
  reg        pdPending;

  // decisions taken at deselect
  wire atWait  = csRise & (sState == S_WAIT);
  wire doWren  = atWait & (opc == `SFCE_OP_WRITE_EN);
  wire doWrdi  = atWait & (opc == `SFCE_OP_WRITE_DIS);
  wire doChip  = atWait & (opc == `SFCE_OP_CHIP_ERASE) & writeEnableLatch
                 & (blockProtectField == 3'h0);
  wire doPd    = atWait & (opc == `SFCE_OP_POWER_DOWN);
  wire doRel   = atWait & (opc == `SFCE_OP_RELEASE_PD);
  wire regionOk = ~isProtected(addr, blockProtectField, topBottomSelect);
  wire doErase = csRise & (sState == S_ADON) & writeEnableLatch & regionOk;
  wire doProg  = csRise & (sState == S_PROG) & (bitCnt == 3'h0) & progGot
                 & writeEnableLatch & regionOk;

  sfce_fifo #(
    .WIDTH (`SFCE_FIFO_WIDTH),
    .DEPTH (`SFCE_FIFO_DEPTH),
    .AW    (`SFCE_FIFO_AW)
  ) readFifo (
    .clk      (clk),
    .rst      (rst),
    .flush    (~csAct),
    .inData   (memRdData),
    .inValid  (rdPush & inRead),
    .inReady  (fifoInReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  // two flip-flops on every pin before any logic looks at it
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      csS1  <= 1'b1;
      csS2  <= 1'b1;
      csS3  <= 1'b1;
      sckS1 <= 1'b0;
      sckS2 <= 1'b0;
      sckS3 <= 1'b0;
      dinS1 <= 1'b0;
      dinS2 <= 1'b0;
    end
    else
    begin
      csS1  <= chipSelectN;
      csS2  <= csS1;
      csS3  <= csS2;
      sckS1 <= serialClock;
      sckS2 <= sckS1;
      sckS3 <= sckS2;
      dinS1 <= serialIoLineIn;
      dinS2 <= dinS1;
    end
  end

  // instruction decoder, advanced on each rising link clock edge
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sState   <= S_OPC;
      bitCnt   <= 3'h0;
      byteIdx  <= 2'h0;
      shIn     <= 8'h00;
      opc      <= 8'h00;
      addr     <= 24'h000000;
      col      <= 8'h00;
      progGot  <= 1'b0;
      pageMask <= {256{1'b0}};
    end
    else if (!csAct)
    begin
      // deselect ends any instruction
      sState  <= S_OPC;
      bitCnt  <= 3'h0;
      byteIdx <= 2'h0;
    end
    else if (riseEv)
    begin
      bitCnt <= bitCnt + 3'h1;
      shIn   <= inByte;
      case (sState)
        S_OPC:
        begin
          if (bitCnt == 3'h7)
          begin
            opc <= inByte;
            if (powerDown)
              sState <= (inByte == `SFCE_OP_RELEASE_PD) ? S_WAIT : S_IGN;
            else if (busy)
              sState <= (inByte == `SFCE_OP_READ_STATUS) ? S_STAT : S_IGN;
            else if (inByte == `SFCE_OP_READ || inByte == `SFCE_OP_FAST_READ ||
                     inByte == `SFCE_OP_DUAL_READ || inByte == `SFCE_OP_PAGE_PROG ||
                     inByte == `SFCE_OP_SECT_ERASE || inByte == `SFCE_OP_BLOCK_ERASE)
              sState <= S_ADDR;
            else if (inByte == `SFCE_OP_READ_STATUS)
              sState <= S_STAT;
            else if (inByte == `SFCE_OP_WRITE_EN || inByte == `SFCE_OP_WRITE_DIS ||
                     inByte == `SFCE_OP_CHIP_ERASE || inByte == `SFCE_OP_POWER_DOWN ||
                     inByte == `SFCE_OP_RELEASE_PD)
              sState <= S_WAIT;
            else
              sState <= S_IGN;
            // a new program starts with a clean page; a refused one must not wipe a running scan
            if (inByte == `SFCE_OP_PAGE_PROG && !busy && !powerDown)
            begin
              pageMask <= {256{1'b0}};
              progGot  <= 1'b0;
            end
          end
        end
        S_ADDR:
        begin
          addr <= {addr[22:0], dinS2};
          if (bitCnt == 3'h7)
          begin
            byteIdx <= byteIdx + 2'h1;
            if (byteIdx == 2'h2)
            begin
              if (opc == `SFCE_OP_READ)
                sState <= S_RD;
              else if (opc == `SFCE_OP_PAGE_PROG)
                sState <= S_PROG;
              else if (opc == `SFCE_OP_SECT_ERASE || opc == `SFCE_OP_BLOCK_ERASE)
                sState <= S_ADON;
              else
                sState <= S_DUM;
              col <= addr[6:0] == 7'h00 ? {addr[6:0], dinS2} : {addr[6:0], dinS2};
            end
          end
        end
        S_DUM:
        begin
          // input value is a don't care here
          if (bitCnt == 3'h7)
            sState <= S_RD;
        end
        S_PROG:
        begin
          if (bitCnt == 3'h7)
          begin
            pageMask[col] <= 1'b1;
            col           <= col + 8'h01;
            progGot       <= 1'b1;
          end
        end
        S_WAIT, S_ADON:
          sState <= S_IGN;
        default:
          sState <= sState;
      endcase
    end
  end

  // page buffer takes each completed program byte at its wrapped column
  always @(posedge clk)
  begin
    if (riseEv && sState == S_PROG && bitCnt == 3'h7)
      pageBuf[col] <= inByte;
  end

  // output shifter, driven on each falling link clock edge
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dataOut         <= 1'b0;
      serialIoLineOut <= 1'b0;
      serialIoLineOe  <= 1'b0;
      outBit          <= 3'h0;
      outSh           <= 8'h00;
    end
    else if (!csAct)
    begin
      serialIoLineOe <= 1'b0;
      outBit         <= 3'h0;
    end
    else if (fallEv && (sState == S_RD || sState == S_STAT))
    begin
      if (sState == S_RD && dual)
      begin
        // two bits a fall: odd bit on output, even bit on io line
        serialIoLineOe <= 1'b1;
        outBit         <= (outBit == 3'h3) ? 3'h0 : outBit + 3'h1;
        if (outBit == 3'h0)
        begin
          dataOut         <= fifoData[7];
          serialIoLineOut <= fifoData[6];
          outSh           <= {fifoData[5:0], 2'h0};
        end
        else
        begin
          dataOut         <= outSh[7];
          serialIoLineOut <= outSh[6];
          outSh           <= {outSh[5:0], 2'h0};
        end
      end
      else
      begin
        outBit <= outBit + 3'h1;
        if (outBit == 3'h0)
        begin
          // status repeats for as long as clocks come
          dataOut <= (sState == S_STAT) ? statusByte[7] : fifoData[7];
          outSh   <= (sState == S_STAT) ? {statusByte[6:0], 1'b0} : {fifoData[6:0], 1'b0};
        end
        else
        begin
          dataOut <= outSh[7];
          outSh   <= {outSh[6:0], 1'b0};
        end
      end
    end
  end

  // prefetch: one request in flight, stalled by a full fifo
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdAddr    <= 24'h000000;
      memRdEn   <= 1'b0;
      memRdAddr <= 24'h000000;
      rdPush    <= 1'b0;
    end
    else
    begin
      rdPush  <= memRdEn;
      memRdEn <= 1'b0;
      // the last address bit lands in addr on this same edge, so take it from the pin here
      if (!inRead)
        rdAddr <= {addr[22:0], dinS2};
      else if (fifoInReady && !memRdEn && !rdPush)
      begin
        memRdEn   <= 1'b1;
        memRdAddr <= rdAddr;
        rdAddr    <= rdAddr + 24'h000001;
      end
    end
  end

  // self-timed program and erase cycles, latch and power-down state
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      xState           <= X_IDLE;
      busy             <= 1'b0;
      writeEnableLatch <= 1'b0;
      powerDown        <= 1'b0;
      pdPending        <= 1'b0;
      pdCnt            <= 16'h0000;
      wrIdx            <= 8'h00;
      timer            <= 32'h00000000;
      memWrEn          <= 1'b0;
      memWrAddr        <= 24'h000000;
      memWrData        <= 8'h00;
      memEraseEn       <= 1'b0;
      memEraseAddr     <= 24'h000000;
      memEraseKind     <= `SFCE_ERASE_SECTOR;
    end
    else
    begin
      memWrEn    <= 1'b0;
      memEraseEn <= 1'b0;
      // power-down entry delay
      if (pdPending)
      begin
        pdCnt <= pdCnt - 16'h0001;
        if (pdCnt == 16'h0001)
        begin
          pdPending <= 1'b0;
          powerDown <= 1'b1;
        end
      end
      case (xState)
        X_IDLE:
        begin
          if (doWren)
            writeEnableLatch <= 1'b1;
          else if (doWrdi)
            writeEnableLatch <= 1'b0;
          if (doRel)
            powerDown <= 1'b0;
          if (doPd)
          begin
            pdPending <= 1'b1;
            pdCnt     <= PD_LOAD[15:0];
          end
          if (doProg)
          begin
            busy   <= 1'b1;
            wrIdx  <= 8'h00;
            xState <= X_WR;
          end
          else if (doErase || doChip)
          begin
            busy         <= 1'b1;
            memEraseEn   <= 1'b1;
            memEraseAddr <= addr;
            xState       <= X_TIME;
            if (doChip)
            begin
              memEraseKind <= `SFCE_ERASE_CHIP;
              timer        <= CHIP_CYCLES;
            end
            else if (opc == `SFCE_OP_SECT_ERASE)
            begin
              memEraseKind <= `SFCE_ERASE_SECTOR;
              timer        <= SECT_CYCLES;
            end
            else
            begin
              memEraseKind <= `SFCE_ERASE_BLOCK;
              timer        <= BLOCK_CYCLES;
            end
          end
        end
        X_WR:
        begin
          // only bytes sent by the host touch the array
          if (pageMask[wrIdx])
          begin
            memWrEn   <= 1'b1;
            memWrAddr <= {addr[23:8], wrIdx};
            memWrData <= pageBuf[wrIdx];
          end
          wrIdx <= wrIdx + 8'h01;
          if (wrIdx == 8'hff)
          begin
            timer  <= PROG_CYCLES;
            xState <= X_TIME;
          end
        end
        X_TIME:
        begin
          timer <= timer - 32'h00000001;
          if (timer <= 32'h00000001)
          begin
            busy             <= 1'b0;
            writeEnableLatch <= 1'b0;
            xState           <= X_IDLE;
          end
        end
        default:
          xState <= X_IDLE;
      endcase
    end
  end
endmodule

`default_nettype wire

// [sfce_engine_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module sfce_engine_assertions (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // link and status
  input wire logic       chipSelectN,
  input wire logic       serialIoLineOe,
  input wire logic [2:0] blockProtectField,
  input wire logic       busy,
  input wire logic       writeEnableLatch,
  input wire logic       powerDown,
  // array ports
  input wire logic       memRdEn,
  input wire logic       memWrEn,
  input wire logic       memEraseEn,
  input wire logic [1:0] memEraseKind
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // latch is cleared only by 04h or when the cycle ends, and 04h is refused while busy, so it is still set here
  a_erase_wel: assert property (memEraseEn |-> writeEnableLatch)
    else $error("erase without write enable");
  a_write_wel: assert property (memWrEn |-> busy && writeEnableLatch)
    else $error("program outside a busy cycle");
  a_read_idle: assert property (memRdEn |-> !busy)
    else $error("array read while busy");
  a_busy_end: assert property ($fell(busy) |-> !writeEnableLatch)
    else $error("latch kept after cycle");
  a_chip_prot: assert property (memEraseEn && memEraseKind == 2'h2 |-> blockProtectField == 3'h0)
    else $error("chip erase with protection");
  // erase counts are kept at 8 or more in the bench
  a_erase_busy: assert property (memEraseEn |=> busy [*8])
    else $error("busy short after erase");
  a_oe_release: assert property ($rose(chipSelectN) |-> ##[1:6] !serialIoLineOe)
    else $error("io line held after deselect");
  a_pd_silent: assert property (powerDown |-> !(memRdEn || memWrEn || memEraseEn))
    else $error("array access in power-down");
endmodule
bind sfce_engine sfce_engine_assertions chk (.clk, .rst, .chipSelectN, .serialIoLineOe, .blockProtectField,
  .busy, .writeEnableLatch, .powerDown, .memRdEn, .memWrEn, .memEraseEn, .memEraseKind);
`default_nettype wire

// [sfce_engine_test.sv]
`timescale 1ns/1ps
`default_nettype none
module sfce_engine_test;
  logic clk, rst, csN, sck, ioIn, ioOut, ioOe, dOut, tbSel, busy, write_enable_latch, pd;
  logic memRdEn, memWrEn, memEraseEn;
  logic [2:0] bp;
  logic [1:0] eKind, lastKind;
  logic [7:0] memRdData, memWrData, r, s;
  logic [23:0] memRdAddr, memWrAddr, memEraseAddr;
  logic [7:0] mem [int]; // sparse array, absent bytes read erased
  int failures = 0;
  int n_tests = 0;
  int sz, base, i;
  // long cycles shortened; program kept long enough to poll
  sfce_engine #(.PROG_CYCLES(2000), .SECT_CYCLES(30), .BLOCK_CYCLES(40), .CHIP_CYCLES(50)) uut (
    .clk, .rst, .chipSelectN(csN), .serialClock(sck), .serialIoLineIn(ioIn), .serialIoLineOut(ioOut),
    .serialIoLineOe(ioOe), .dataOut(dOut), .blockProtectField(bp), .topBottomSelect(tbSel), .busy,
    .writeEnableLatch(write_enable_latch), .powerDown(pd), .memRdEn, .memRdAddr, .memRdData, .memWrEn, .memWrAddr,
    .memWrData, .memEraseEn, .memEraseAddr, .memEraseKind(eKind));
  sfce_host h (.chipSelectN(csN), .serialClock(sck), .serialIoLineIn(ioIn), .dataOut(dOut),
    .serialIoLineOut(ioOut), .serialIoLineOe(ioOe));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [7:0] rd(input logic [23:0] a);
    return mem.exists(int'(a[19:0])) ? mem[int'(a[19:0])] : 8'hff;
  endfunction
  // array model: read data one clk late, program ands, erase drops bytes
  always @(posedge clk)
  begin
    memRdData <= rd(memRdAddr);
    if (memWrEn) mem[int'(memWrAddr[19:0])] = rd(memWrAddr) & memWrData;
    if (memEraseEn)
    begin
      lastKind = eKind;
      sz = eKind == 2'h0 ? 4096 : 65536;
      base = int'(memEraseAddr[19:0]) & ~(sz - 1);
      if (eKind == 2'h2) mem.delete();
      else for (i = 0; i < sz; i++) mem.delete(base + i);
    end
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task op1(input logic [7:0] op);
    h.start();
    h.tx(op, r);
    h.stop();
  endtask
  task hdr(input logic [7:0] op, input logic [23:0] a);
    h.start();
    h.tx(op, r);
    h.tx(a[23:16], r);
    h.tx(a[15:8], r);
    h.tx(a[7:0], r);
  endtask
  task stat();
    h.start();
    h.tx(8'h05, s);
    h.tx(8'h00, s);
    h.stop();
  endtask
  // poll busy under a bound
  task idle();
    s = 8'h01;
    for (int k = 0; k < 20 && s[0] !== 1'b0; k++) stat();
    check({7'h00, s[0]}, 8'h00);
  endtask
  // read two bytes; 0b and 3b add a dummy byte with the io line released
  task rd2(input logic [7:0] op, input logic [23:0] a, input logic [15:0] e);
    hdr(op, a);
    if (op != 8'h03)
    begin
      h.hostDrv = 1'b0;
      h.tx(8'h00, r);
      h.dual = op[4];
    end
    h.tx(8'h00, r);
    check(r, e[15:8]);
    h.tx(8'h00, r);
    check(r, e[7:0]);
    h.stop();
  endtask
  initial
  begin
    rst = 1'b1;
    bp = 3'h0;
    tbSel = 1'b0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check({5'h00, busy, write_enable_latch, pd}, 8'h00);
    op1(8'h06);
    check({7'h00, write_enable_latch}, 8'h01);
    hdr(8'h02, 24'h0001fe);
    h.tx(8'h12, r);
    h.tx(8'h34, r);
    h.tx(8'h56, r);
    h.stop();
    // the refused read doubles as the wait before the first busy poll
    hdr(8'h03, 24'h0001fe);
    h.stop();
    stat();
    check(s, 8'h03);
    idle();
    check({7'h00, write_enable_latch}, 8'h00);
    hdr(8'h02, 24'h000100);
    h.tx(8'h00, r);
    h.stop();
    rd2(8'h03, 24'h0001fe, 16'h1234);
    rd2(8'h0b, 24'h000100, 16'h56ff);
    rd2(8'h3b, 24'h0001fe, 16'h1234);
    @(negedge clk) bp = 3'h7;
    op1(8'h06);
    hdr(8'h02, 24'h0001fe);
    h.tx(8'h00, r);
    h.stop();
    op1(8'hc7);
    stat();
    check(s, 8'h1e);
    // smallest region: bottom covers sector 0, top does not
    @(negedge clk) bp = 3'h1;
    tbSel = 1'b1;
    hdr(8'h20, 24'h000123);
    h.stop();
    stat();
    check(s, 8'h26);
    @(negedge clk) tbSel = 1'b0;
    hdr(8'h20, 24'h000123);
    h.stop();
    stat();
    check(s, 8'h04);
    @(negedge clk) bp = 3'h0;
    op1(8'h06);
    hdr(8'h20, 24'h000123);
    h.tx(8'h00, r);
    h.stop();
    stat();
    check(s, 8'h02);
    hdr(8'h20, 24'h000123);
    h.stop();
    idle();
    check({6'h00, lastKind}, 8'h00);
    rd2(8'h03, 24'h0001fe, 16'hffff);
    op1(8'h06);
    hdr(8'hd8, 24'h012345);
    h.stop();
    idle();
    check({6'h00, lastKind}, 8'h01);
    op1(8'h06);
    op1(8'hc7);
    idle();
    check({6'h00, lastKind}, 8'h02);
    op1(8'h06);
    op1(8'hb9);
    repeat (760) @(negedge clk);
    check({7'h00, pd}, 8'h01);
    op1(8'h04);
    check({7'h00, write_enable_latch}, 8'h01);
    op1(8'hab);
    check({7'h00, pd}, 8'h00);
    end_of_test();
  end
  // watchdog well past the expected run
  initial
  begin
    #300000;
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire

// [sfce_host.sv]
`timescale 1ns/1ps
`default_nettype none
module sfce_host (
  // link pins toward the device
  output logic      chipSelectN,
  output logic      serialClock,
  output wire logic serialIoLineIn,
  // device answers
  input wire logic  dataOut,
  input wire logic  serialIoLineOut,
  input wire logic  serialIoLineOe
);
  logic mosi;    // host data bit
  logic hostDrv; // host owns the io line
  logic dual;    // two bits per clock
  // released line floats, so give it a value that keeps moving
  assign serialIoLineIn = serialIoLineOe ? serialIoLineOut : hostDrv ? mosi : serialClock;
  initial
  begin
    chipSelectN = 1'b1;
    serialClock = 1'b0;
    mosi = 1'b0;
    hostDrv = 1'b1;
    dual = 1'b0;
  end
  // open a frame, clock idles low
  task start();
    hostDrv = 1'b1;
    chipSelectN = 1'b0;
    #62.5;
  endtask
  // one byte msb first; data set while clock low, answer taken at rise
  task tx(input logic [7:0] b, output logic [7:0] r);
    int i;
    for (i = 7; i >= 0; i = i - (dual ? 2 : 1))
    begin
      mosi = b[i];
      #62.5 serialClock = 1'b1;
      r = dual ? {r[5:0], dataOut, serialIoLineIn} : {r[6:0], dataOut};
      #62.5 serialClock = 1'b0;
    end
  endtask
  // deselect right after the last full byte, then keep gap
  task stop();
    #62.5 chipSelectN = 1'b1;
    dual = 1'b0;
    hostDrv = 1'b1;
    #40;
  endtask
endmodule
`default_nettype wire
